// ---- rtl/pde_pkg.sv ----
// constants and types for the port d / port e pin-sharing block
package pde_pkg;
  localparam int PDE_PD_W = 7;
  localparam int PDE_PE_W = 3;
  localparam int PDE_PC_W = 6;
  // register offsets
  localparam logic [7:0] PDE_OFS_PD_LATCH = 8'h03;
  localparam logic [7:0] PDE_OFS_PD_DIR   = 8'h07;
  localparam logic [7:0] PDE_OFS_PE_LATCH = 8'h08;
  localparam logic [7:0] PDE_OFS_PE_DIR   = 8'h09;
  localparam logic [7:0] PDE_OFS_PD_FSEL  = 8'h0a;
  localparam logic [7:0] PDE_OFS_SETUP0   = 8'h1f;
  // port d function-select fields
  localparam int PDE_FSEL_PULSE_BIT = 0;
  localparam int PDE_FSEL_DATA_BIT  = 1;
  localparam int PDE_FSEL_CLOCK_BIT = 2;
  // setup-zero fields
  localparam int PDE_CFG_HSYNC_BIT = 0;
  localparam int PDE_CFG_VSYNC_BIT = 1;
  localparam int PDE_CFG_GREEN_BIT = 2;
  // pins used by module functions
  localparam int PDE_PD_PULSE_PIN = 4;
  localparam int PDE_PD_CLOCK_PIN = 3;
  localparam int PDE_PD_DATA_PIN  = 2;
  localparam int PDE_PE_VSYNC_PIN = 2;
  localparam int PDE_PE_HSYNC_PIN = 1;
  localparam int PDE_PE_GREEN_PIN = 0;
  // reset values
  localparam logic [6:0] PDE_RST_PD_DIR  = 7'h00;
  localparam logic [2:0] PDE_RST_PE_DIR  = 3'h0;
  localparam logic [2:0] PDE_RST_PD_FSEL = 3'h0;
  localparam logic [2:0] PDE_RST_SETUP0  = 3'h0;
  localparam logic [7:0] PDE_RST_RDATA   = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pde_bus_req_s;

  // one-hot port c pin picked by the converter channel select, all zero for selects above 5
  function automatic logic [PDE_PC_W-1:0] pde_chan_dec(input logic [4:0] sel);
    logic [PDE_PC_W-1:0] hot;
    hot = '0;
    for (int i = 0; i < PDE_PC_W; i++) begin
      if (sel == 5'(i)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction
endpackage

// ---- rtl/pde_pin_cell.sv ----
// pad cell group: input synchroniser and registered output mux
module pde_pin_cell #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // port control
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  // module function
  input  wire logic [W-1:0] fn_en,
  input  wire logic [W-1:0] fn_out,
  input  wire logic [W-1:0] fn_oe,
  // pads
  input  wire logic [W-1:0] pad_in,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe,
  output logic      [W-1:0] pin_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;
  logic [W-1:0] oe_q;
  logic [W-1:0] oe_d;

  // module function takes the pin over from latch and direction
  always_comb begin
    out_d = (fn_en & fn_out) | (~fn_en & latch);
    oe_d  = (fn_en & fn_oe) | (~fn_en & dir);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      out_q <= '0;
      oe_q  <= '0;
    end else begin
      s1_q  <= pad_in;
      s2_q  <= s1_q;
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pad_out   = out_q;
  assign pad_oe    = oe_q;
  assign pin_level = s2_q;
endmodule

// ---- rtl/pde_gpio.sv ----
// port d and port e pin-sharing logic with port c analog override
// Function
// - converter channel forces port c pin analog
// - seven port d latches, kept through reset
// - port d direction one drives, reset clears
// - port d read: latch if output, else pin
// - latch writes always land, inputs unaffected
// - pulse enable gives pin d4 clamp pulse
// - clock enable gives pin d3 link clock
// - data enable gives pin d2 link data
// - three port e directions, reset clears
// - port e read: latch if output, else pin
// - hsync enable drives pin e1
// - vsync enable drives pin e2
// - green enable or timer capture on e0
//
// The address-and-strobe port was decided locally.
module pde_gpio
  import pde_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // register port
  input  wire logic [7:0]          bus_addr,
  input  wire logic [7:0]          bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [7:0]          bus_rdata,
  // port d pads
  input  wire logic [PDE_PD_W-1:0] pd_pad_in,
  output logic      [PDE_PD_W-1:0] pd_pad_out,
  output logic      [PDE_PD_W-1:0] pd_pad_oe,
  // port e pads
  input  wire logic [PDE_PE_W-1:0] pe_pad_in,
  output logic      [PDE_PE_W-1:0] pe_pad_out,
  output logic      [PDE_PE_W-1:0] pe_pad_oe,
  // sync processor
  input  wire logic                clamp_pulse,
  input  wire logic                horizontal_sync_out,
  input  wire logic                vertical_sync_out,
  output logic                     green_channel_sync_in,
  // display link serial module
  input  wire logic                link_clock_drive_low,
  input  wire logic                link_data_drive_low,
  output logic                     display_link_clock_line,
  output logic                     display_link_data_line,
  // timer channel 0
  input  wire logic                timer_ch0_edge_select_high,
  input  wire logic                timer_ch0_edge_select_low,
  output logic                     timer_ch0_capture_input,
  // port c override
  input  wire logic [4:0]          converter_channel_select,
  input  wire logic [PDE_PC_W-1:0] pc_dir,
  input  wire logic [PDE_PC_W-1:0] pc_latch,
  output logic      [PDE_PC_W-1:0] pc_pad_out,
  output logic      [PDE_PC_W-1:0] pc_pad_oe,
  output logic      [PDE_PC_W-1:0] pc_analog_sel
);
  pde_bus_req_s req;
  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // registers
  logic [PDE_PD_W-1:0] port_d_latch_q;
  logic [PDE_PD_W-1:0] port_d_latch_d;
  logic [PDE_PE_W-1:0] port_e_latch_q;
  logic [PDE_PE_W-1:0] port_e_latch_d;
  logic [PDE_PD_W-1:0] port_d_direction_q;
  logic [PDE_PD_W-1:0] port_d_direction_d;
  logic [PDE_PE_W-1:0] port_e_direction_q;
  logic [PDE_PE_W-1:0] port_e_direction_d;
  logic [2:0]          port_d_function_select_q;
  logic [2:0]          port_d_function_select_d;
  logic [2:0]          chip_setup_zero_q;
  logic [2:0]          chip_setup_zero_d;
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;
  // pin side
  logic [PDE_PD_W-1:0] pd_level;
  logic [PDE_PE_W-1:0] pe_level;
  logic [PDE_PD_W-1:0] pd_fn_en;
  logic [PDE_PD_W-1:0] pd_fn_out;
  logic [PDE_PD_W-1:0] pd_fn_oe;
  logic [PDE_PE_W-1:0] pe_fn_en;
  logic [PDE_PE_W-1:0] pe_fn_out;
  logic [PDE_PE_W-1:0] pe_fn_oe;
  logic [PDE_PD_W-1:0] pd_view;
  logic [PDE_PE_W-1:0] pe_view;
  // module-facing outputs
  logic                green_q;
  logic                green_d;
  logic                capture_q;
  logic                capture_d;
  logic                link_clk_q;
  logic                link_clk_d;
  logic                link_dat_q;
  logic                link_dat_d;
  logic [PDE_PC_W-1:0] pc_out_q;
  logic [PDE_PC_W-1:0] pc_out_d;
  logic [PDE_PC_W-1:0] pc_oe_q;
  logic [PDE_PC_W-1:0] pc_oe_d;
  logic [PDE_PC_W-1:0] pc_ana_q;
  logic [PDE_PC_W-1:0] pc_ana_d;
  logic                tim_edge_on;

  // register writes and read data
  always_comb begin
    port_d_latch_d           = port_d_latch_q;
    port_e_latch_d           = port_e_latch_q;
    port_d_direction_d       = port_d_direction_q;
    port_e_direction_d       = port_e_direction_q;
    port_d_function_select_d = port_d_function_select_q;
    chip_setup_zero_d        = chip_setup_zero_q;
    pd_view = (port_d_direction_q & port_d_latch_q) | (~port_d_direction_q & pd_level);
    pe_view = (port_e_direction_q & port_e_latch_q) | (~port_e_direction_q & pe_level);
    if (req.wr) begin
      case (req.addr)
        PDE_OFS_PD_LATCH: port_d_latch_d = req.wdata[PDE_PD_W-1:0];
        PDE_OFS_PE_LATCH: port_e_latch_d = req.wdata[PDE_PE_W-1:0];
        PDE_OFS_PD_DIR:   port_d_direction_d = req.wdata[PDE_PD_W-1:0];
        PDE_OFS_PE_DIR:   port_e_direction_d = req.wdata[PDE_PE_W-1:0];
        PDE_OFS_PD_FSEL:  port_d_function_select_d = req.wdata[2:0];
        PDE_OFS_SETUP0:   chip_setup_zero_d = req.wdata[2:0];
        default: ;
      endcase
    end
    rdata_d = PDE_RST_RDATA;
    if (req.rd) begin
      case (req.addr)
        PDE_OFS_PD_LATCH: rdata_d = {1'b0, pd_view};
        PDE_OFS_PE_LATCH: rdata_d = {5'h00, pe_view};
        PDE_OFS_PD_DIR:   rdata_d = {1'b0, port_d_direction_q};
        PDE_OFS_PE_DIR:   rdata_d = {5'h00, port_e_direction_q};
        PDE_OFS_PD_FSEL:  rdata_d = {5'h00, port_d_function_select_q};
        PDE_OFS_SETUP0:   rdata_d = {5'h00, chip_setup_zero_q};
        default:          rdata_d = PDE_RST_RDATA;
      endcase
    end
  end

  // data latches carry no reset
  always_ff @(posedge ref_clk) begin
    port_d_latch_q <= port_d_latch_d;
    port_e_latch_q <= port_e_latch_d;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      port_d_direction_q       <= PDE_RST_PD_DIR;
      port_e_direction_q       <= PDE_RST_PE_DIR;
      port_d_function_select_q <= PDE_RST_PD_FSEL;
      chip_setup_zero_q        <= PDE_RST_SETUP0;
      rdata_q                  <= PDE_RST_RDATA;
    end else begin
      port_d_direction_q       <= port_d_direction_d;
      port_e_direction_q       <= port_e_direction_d;
      port_d_function_select_q <= port_d_function_select_d;
      chip_setup_zero_q        <= chip_setup_zero_d;
      rdata_q                  <= rdata_d;
    end
  end

  // function sources per pin; link lines are open drain
  always_comb begin
    pd_fn_en  = '0;
    pd_fn_out = '0;
    pd_fn_oe  = '0;
    pe_fn_en  = '0;
    pe_fn_out = '0;
    pe_fn_oe  = '0;
    pd_fn_en[PDE_PD_PULSE_PIN]  = port_d_function_select_q[PDE_FSEL_PULSE_BIT];
    pd_fn_out[PDE_PD_PULSE_PIN] = clamp_pulse;
    pd_fn_oe[PDE_PD_PULSE_PIN]  = 1'b1;
    pd_fn_en[PDE_PD_CLOCK_PIN]  = port_d_function_select_q[PDE_FSEL_CLOCK_BIT];
    pd_fn_oe[PDE_PD_CLOCK_PIN]  = link_clock_drive_low;
    pd_fn_en[PDE_PD_DATA_PIN]   = port_d_function_select_q[PDE_FSEL_DATA_BIT];
    pd_fn_oe[PDE_PD_DATA_PIN]   = link_data_drive_low;
    pe_fn_en[PDE_PE_HSYNC_PIN]  = chip_setup_zero_q[PDE_CFG_HSYNC_BIT];
    pe_fn_out[PDE_PE_HSYNC_PIN] = horizontal_sync_out;
    pe_fn_oe[PDE_PE_HSYNC_PIN]  = 1'b1;
    pe_fn_en[PDE_PE_VSYNC_PIN]  = chip_setup_zero_q[PDE_CFG_VSYNC_BIT];
    pe_fn_out[PDE_PE_VSYNC_PIN] = vertical_sync_out;
    pe_fn_oe[PDE_PE_VSYNC_PIN]  = 1'b1;
    pe_fn_en[PDE_PE_GREEN_PIN]  = chip_setup_zero_q[PDE_CFG_GREEN_BIT];
  end

  pde_pin_cell #(.W(PDE_PD_W)) u_port_d (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .latch     (port_d_latch_q),
    .dir       (port_d_direction_q),
    .fn_en     (pd_fn_en),
    .fn_out    (pd_fn_out),
    .fn_oe     (pd_fn_oe),
    .pad_in    (pd_pad_in),
    .pad_out   (pd_pad_out),
    .pad_oe    (pd_pad_oe),
    .pin_level (pd_level)
  );

  pde_pin_cell #(.W(PDE_PE_W)) u_port_e (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .latch     (port_e_latch_q),
    .dir       (port_e_direction_q),
    .fn_en     (pe_fn_en),
    .fn_out    (pe_fn_out),
    .fn_oe     (pe_fn_oe),
    .pad_in    (pe_pad_in),
    .pad_out   (pe_pad_out),
    .pad_oe    (pe_pad_oe),
    .pin_level (pe_level)
  );

  // inputs handed to modules, and port c override
  always_comb begin
    tim_edge_on = timer_ch0_edge_select_high | timer_ch0_edge_select_low;
    green_d     = chip_setup_zero_q[PDE_CFG_GREEN_BIT] & pe_level[PDE_PE_GREEN_PIN];
    capture_d   = ~chip_setup_zero_q[PDE_CFG_GREEN_BIT] & tim_edge_on
                  & pe_level[PDE_PE_GREEN_PIN];
    link_clk_d  = pd_level[PDE_PD_CLOCK_PIN] | ~port_d_function_select_q[PDE_FSEL_CLOCK_BIT];
    link_dat_d  = pd_level[PDE_PD_DATA_PIN] | ~port_d_function_select_q[PDE_FSEL_DATA_BIT];
    pc_ana_d    = pde_chan_dec(converter_channel_select);
    pc_oe_d     = pc_dir & ~pc_ana_d;
    pc_out_d    = pc_latch & ~pc_ana_d;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      green_q    <= 1'b0;
      capture_q  <= 1'b0;
      link_clk_q <= 1'b1;
      link_dat_q <= 1'b1;
      pc_ana_q   <= '0;
      pc_oe_q    <= '0;
      pc_out_q   <= '0;
    end else begin
      green_q    <= green_d;
      capture_q  <= capture_d;
      link_clk_q <= link_clk_d;
      link_dat_q <= link_dat_d;
      pc_ana_q   <= pc_ana_d;
      pc_oe_q    <= pc_oe_d;
      pc_out_q   <= pc_out_d;
    end
  end

  assign bus_rdata               = rdata_q;
  assign green_channel_sync_in   = green_q;
  assign timer_ch0_capture_input = capture_q;
  assign display_link_clock_line = link_clk_q;
  assign display_link_data_line  = link_dat_q;
  assign pc_analog_sel           = pc_ana_q;
  assign pc_pad_oe               = pc_oe_q;
  assign pc_pad_out              = pc_out_q;

  // checks
  property p_pc_analog;
    @(posedge ref_clk) disable iff (!resetn)
    resetn |=> (pc_analog_sel == pde_chan_dec($past(converter_channel_select)))
             && ((pc_pad_oe & pc_analog_sel) == '0);
  endproperty
  a_pc_analog: assert property (p_pc_analog) else $error("port c analog override wrong");

  property p_pd_latch_hold;
    @(posedge ref_clk)
    (!resetn && $past(resetn) && !bus_wr) |=> (port_d_latch_q == $past(port_d_latch_q));
  endproperty
  a_pd_latch_hold: assert property (p_pd_latch_hold) else $error("reset touched latch");

  property p_dir_reset;
    @(posedge ref_clk)
    !resetn |=> (port_d_direction_q == '0) && (port_e_direction_q == '0) ##1 !resetn
             || (pd_pad_oe & ~pd_fn_en) == '0;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  property p_pd_read;
    @(posedge ref_clk) disable iff (!resetn)
    (bus_rd && bus_addr == PDE_OFS_PD_LATCH) |=>
      bus_rdata == {1'b0, ($past(port_d_direction_q) & $past(port_d_latch_q))
                        | (~$past(port_d_direction_q) & $past(pd_level))};
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("port d read wrong");

  property p_pe_read;
    @(posedge ref_clk) disable iff (!resetn)
    (bus_rd && bus_addr == PDE_OFS_PE_LATCH) |=>
      bus_rdata == {5'h00, ($past(port_e_direction_q) & $past(port_e_latch_q))
                         | (~$past(port_e_direction_q) & $past(pe_level))};
  endproperty
  a_pe_read: assert property (p_pe_read) else $error("port e read wrong");

  property p_latch_write;
    @(posedge ref_clk) disable iff (!resetn)
    (bus_wr && bus_addr == PDE_OFS_PD_LATCH) |=> port_d_latch_q == $past(bus_wdata[6:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  property p_pulse_pin;
    @(posedge ref_clk) disable iff (!resetn)
    port_d_function_select_q[PDE_FSEL_PULSE_BIT] |=>
      pd_pad_oe[PDE_PD_PULSE_PIN] && pd_pad_out[PDE_PD_PULSE_PIN] == $past(clamp_pulse);
  endproperty
  a_pulse_pin: assert property (p_pulse_pin) else $error("clamp pin wrong");

  property p_link_pins;
    @(posedge ref_clk) disable iff (!resetn)
    (port_d_function_select_q[PDE_FSEL_CLOCK_BIT] && port_d_function_select_q[PDE_FSEL_DATA_BIT])
      |=> !pd_pad_out[PDE_PD_CLOCK_PIN] && !pd_pad_out[PDE_PD_DATA_PIN]
          && pd_pad_oe[PDE_PD_CLOCK_PIN] == $past(link_clock_drive_low)
          && pd_pad_oe[PDE_PD_DATA_PIN] == $past(link_data_drive_low);
  endproperty
  a_link_pins: assert property (p_link_pins) else $error("link pins wrong");

  property p_sync_pins;
    @(posedge ref_clk) disable iff (!resetn)
    (chip_setup_zero_q[PDE_CFG_HSYNC_BIT] && chip_setup_zero_q[PDE_CFG_VSYNC_BIT]) |=>
      pe_pad_oe[PDE_PE_HSYNC_PIN] && pe_pad_oe[PDE_PE_VSYNC_PIN]
      && pe_pad_out[PDE_PE_HSYNC_PIN] == $past(horizontal_sync_out)
      && pe_pad_out[PDE_PE_VSYNC_PIN] == $past(vertical_sync_out);
  endproperty
  a_sync_pins: assert property (p_sync_pins) else $error("sync pins wrong");

  property p_capture;
    @(posedge ref_clk) disable iff (!resetn)
    (!chip_setup_zero_q[PDE_CFG_GREEN_BIT] && !tim_edge_on) |=> !timer_ch0_capture_input;
  endproperty
  a_capture: assert property (p_capture) else $error("capture leaks");

  property p_io_mode;
    @(posedge ref_clk) disable iff (!resetn)
    (port_d_function_select_q == '0) |=> pd_pad_oe == $past(port_d_direction_q);
  endproperty
  a_io_mode: assert property (p_io_mode) else $error("plain io oe wrong");
  c_pd_read: cover property (@(posedge ref_clk) bus_rd && bus_addr == PDE_OFS_PD_LATCH);
  c_link_on: cover property (@(posedge ref_clk) port_d_function_select_q == 3'h7);
  c_sync_on: cover property (@(posedge ref_clk) chip_setup_zero_q == 3'h3 ##1 pe_pad_oe[1]);
endmodule

// ---- tb/pde_board_model.sv ----
// board side of the port d and port e pads: resolves each pad level
module pde_board_model
  import pde_pkg::*;
(
  // port d
  input  wire logic [PDE_PD_W-1:0] pd_pad_out,
  input  wire logic [PDE_PD_W-1:0] pd_pad_oe,
  input  wire logic [PDE_PD_W-1:0] pd_board,
  output logic      [PDE_PD_W-1:0] pd_pad_in,
  // port e
  input  wire logic [PDE_PE_W-1:0] pe_pad_out,
  input  wire logic [PDE_PE_W-1:0] pe_pad_oe,
  input  wire logic [PDE_PE_W-1:0] pe_board,
  output logic      [PDE_PE_W-1:0] pe_pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pad shows its output, a released pad shows the board level
  assign pd_pad_in = (pd_pad_oe & pd_pad_out) | (~pd_pad_oe & pd_board);
  assign pe_pad_in = (pe_pad_oe & pe_pad_out) | (~pe_pad_oe & pe_board);
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the port d / port e pin-sharing block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
  import pde_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       resetn  = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic       bus_wr = 1'b0;
  logic       bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic [6:0] pd_pad_in, pd_pad_out, pd_pad_oe;
  logic [6:0] pd_board = 7'h00;
  logic [2:0] pe_pad_in, pe_pad_out, pe_pad_oe;
  logic [2:0] pe_board = 3'h0;
  logic       clamp_pulse = 1'b0;
  logic       hsync = 1'b0;
  logic       vsync = 1'b0;
  logic       clk_low = 1'b0;
  logic       dat_low = 1'b0;
  logic       els_hi = 1'b0;
  logic       els_lo = 1'b0;
  logic       green, clk_line, dat_line, cap;
  logic [4:0] conv_sel = 5'h00;
  logic [5:0] pc_dir = 6'h00;
  logic [5:0] pc_latch = 6'h00;
  logic [5:0] pc_pad_out, pc_pad_oe, pc_analog_sel, hot;
  logic [7:0] rd_val;
  int         mismatches = 0;
  int         check_count = 0;

  always #5 ref_clk = ~ref_clk;

  pde_gpio i_pde_gpio (
    .ref_clk(ref_clk), .resetn(resetn),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .pd_pad_in(pd_pad_in), .pd_pad_out(pd_pad_out), .pd_pad_oe(pd_pad_oe),
    .pe_pad_in(pe_pad_in), .pe_pad_out(pe_pad_out), .pe_pad_oe(pe_pad_oe),
    .clamp_pulse(clamp_pulse), .horizontal_sync_out(hsync), .vertical_sync_out(vsync),
    .green_channel_sync_in(green),
    .link_clock_drive_low(clk_low), .link_data_drive_low(dat_low),
    .display_link_clock_line(clk_line), .display_link_data_line(dat_line),
    .timer_ch0_edge_select_high(els_hi), .timer_ch0_edge_select_low(els_lo),
    .timer_ch0_capture_input(cap),
    .converter_channel_select(conv_sel), .pc_dir(pc_dir), .pc_latch(pc_latch),
    .pc_pad_out(pc_pad_out), .pc_pad_oe(pc_pad_oe), .pc_analog_sel(pc_analog_sel)
  );

  pde_board_model i_pde_board_model (
    .pd_pad_out(pd_pad_out), .pd_pad_oe(pd_pad_oe), .pd_board(pd_board),
    .pd_pad_in(pd_pad_in),
    .pe_pad_out(pe_pad_out), .pe_pad_oe(pe_pad_oe), .pe_board(pe_board),
    .pe_pad_in(pe_pad_in)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    rd_val = bus_rdata;
    `CHK(rd_val, e)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(1);
    // reset state of control registers, pads and lines
    `CHK(pd_pad_oe, 7'h00)
    `CHK(pe_pad_oe, 3'h0)
    `CHK(clk_line, 1'b1)
    `CHK(dat_line, 1'b1)
    rd_chk(PDE_OFS_PD_DIR, 8'h00);
    rd_chk(PDE_OFS_PE_DIR, 8'h00);
    rd_chk(PDE_OFS_PD_FSEL, 8'h00);
    rd_chk(PDE_OFS_SETUP0, 8'h00);
    wr(8'h40, 8'hff);
    rd_chk(8'h40, 8'h00);
    $display("test reset_values done");
    // port d: input reads pin, output reads latch
    @(posedge ref_clk);
    pd_board <= 7'h2a;
    wr(PDE_OFS_PD_LATCH, 8'h55);
    tick(3);
    rd_chk(PDE_OFS_PD_LATCH, 8'h2a);
    wr(PDE_OFS_PD_DIR, 8'h0f);
    tick(3);
    `CHK(pd_pad_oe, 7'h0f)
    `CHK(pd_pad_out & 7'h0f, 7'h05)
    rd_chk(PDE_OFS_PD_LATCH, 8'h25);
    // latches survive a second reset, directions do not
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(1);
    `CHK(pd_pad_oe, 7'h00)
    wr(PDE_OFS_PD_DIR, 8'hff);
    tick(3);
    rd_chk(PDE_OFS_PD_DIR, 8'h7f);
    rd_chk(PDE_OFS_PD_LATCH, 8'h55);
    `CHK(pd_pad_out, 7'h55)
    $display("test port_d done");
    // port e: mixed directions
    @(posedge ref_clk);
    pe_board <= 3'h5;
    wr(PDE_OFS_PE_LATCH, 8'h02);
    wr(PDE_OFS_PE_DIR, 8'h03);
    tick(3);
    `CHK(pe_pad_oe, 3'h3)
    rd_chk(PDE_OFS_PE_LATCH, 8'h06);
    wr(PDE_OFS_PE_DIR, 8'hff);
    rd_chk(PDE_OFS_PE_DIR, 8'h07);
    $display("test port_e done");
    // module functions own their pins while directions are zero
    wr(PDE_OFS_PD_DIR, 8'h00);
    wr(PDE_OFS_PE_DIR, 8'h00);
    @(posedge ref_clk);
    pd_board <= 7'h0c;
    wr(PDE_OFS_PD_FSEL, 8'h07);
    wr(PDE_OFS_SETUP0, 8'h03);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      clamp_pulse <= v[0];
      hsync       <= v[0];
      vsync       <= ~v[0];
      clk_low     <= v[0];
      dat_low     <= ~v[0];
      tick(6);
      `CHK(pd_pad_oe[4], 1'b1)
      `CHK(pd_pad_out[4], v[0])
      `CHK(pe_pad_oe[2:1], 2'h3)
      `CHK(pe_pad_out[1], v[0])
      `CHK(pe_pad_out[2], ~v[0])
      `CHK(pd_pad_oe[3], v[0])
      `CHK(clk_line, ~v[0])
      `CHK(pd_pad_oe[2], ~v[0])
      `CHK(dat_line, v[0])
    end
    wr(PDE_OFS_PD_FSEL, 8'h00);
    wr(PDE_OFS_SETUP0, 8'h00);
    tick(5);
    `CHK(pd_pad_oe, 7'h00)
    `CHK(pe_pad_oe, 3'h0)
    `CHK(clk_line, 1'b1)
    `CHK(dat_line, 1'b1)
    $display("test module_functions done");
    // green sync versus timer capture on pin e0
    @(posedge ref_clk);
    pe_board <= 3'h1;
    els_hi   <= 1'b1;
    wr(PDE_OFS_SETUP0, 8'h04);
    tick(5);
    `CHK(green, 1'b1)
    `CHK(cap, 1'b0)
    `CHK(pe_pad_oe[0], 1'b0)
    wr(PDE_OFS_SETUP0, 8'h00);
    for (int e = 0; e < 8; e++) begin
      @(posedge ref_clk);
      pe_board <= {2'b00, e[2]};
      els_hi   <= e[1];
      els_lo   <= e[0];
      tick(5);
      `CHK(cap, e[2] & (e[1] | e[0]))
      `CHK(green, 1'b0)
    end
    $display("test capture done");
    // converter channel forces its port c pin analog
    @(posedge ref_clk);
    pc_dir   <= 6'h3f;
    pc_latch <= 6'h2d;
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      conv_sel <= 5'(s);
      tick(3);
      hot = (s < 6) ? 6'(1 << s) : 6'h00;
      `CHK(pc_analog_sel, hot)
      `CHK(pc_pad_oe, 6'h3f & ~hot)
      `CHK(pc_pad_out, 6'h2d & ~hot)
    end
    $display("test port_c_override done");
    print_verdict();
  end
endmodule
